// ---- core/smc_pkg.sv ----
// constants, register map and state codes of the standby mode controller
package smc_pkg;

   // ==========================================================
   // bus geometry and register offsets
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int SRC_W  = 8;

   localparam logic [ADDR_W-1:0] ADDR_MODE   = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_DOZE   = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_IRQCFG = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_SRCEN  = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h4;

   // ==========================================================
   // field positions
   localparam int BIT_RELEASE_LEVEL_SELECT     = 0;
   localparam int BIT_WUT_LO   = 1;
   localparam int BIT_WUT_HI   = 3;
   localparam int BIT_DUAL     = 4;
   localparam int BIT_SLOW     = 5;
   localparam int BIT_HALT_CMD = 7;
   localparam int BIT_CPU_HALT = 0;
   localparam int BIT_PCLK_HLT = 1;
   localparam int BIT_MIE      = 0;
   localparam int BIT_TBIE     = 1;
   localparam int BIT_TBEN     = 2;

   // ==========================================================
   // reset values
   localparam logic [2:0]       WUT_RST   = 3'h0;
   localparam logic [SRC_W-1:0] SRCEN_RST = 8'h00;
   localparam logic [DATA_W-1:0] RD_ZERO  = 8'h00;

   // ==========================================================
   // warm-up times, ns, settings 000,010,100,110,*01,*11
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned WARM_FAST_NS [0:5] =
      '{12288000, 4096000, 3072000, 1024000, 192000, 64000};
   localparam int unsigned WARM_SLOW_NS [0:5] =
      '{750000000, 250000000, 5850000, 1950000, 5900000, 2000000};

   // least time: round up, never below one cycle
   function automatic int unsigned ns2cyc(input int unsigned t);
      int unsigned c;
      c = (t + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c == 0) ? 1 : c;
   endfunction

   // ==========================================================
   // controller states
   typedef enum logic [4:0] {
      ST_RUN   = 5'h01,
      ST_HALT  = 5'h02,
      ST_WARM  = 5'h04,
      ST_CDOZE = 5'h08,
      ST_GDOZE = 5'h10
   } smc_state_e;

endpackage

// ---- core/smc_top.sv ----
// standby mode controller: deep halt, cpu doze and gated doze
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module smc_top
   import smc_pkg::*;
#(
   parameter int unsigned WARM_FAST_CYC [0:5] = '{
      ns2cyc(WARM_FAST_NS[0]), ns2cyc(WARM_FAST_NS[1]),
      ns2cyc(WARM_FAST_NS[2]), ns2cyc(WARM_FAST_NS[3]),
      ns2cyc(WARM_FAST_NS[4]), ns2cyc(WARM_FAST_NS[5])},
   parameter int unsigned WARM_SLOW_CYC [0:5] = '{
      ns2cyc(WARM_SLOW_NS[0]), ns2cyc(WARM_SLOW_NS[1]),
      ns2cyc(WARM_SLOW_NS[2]), ns2cyc(WARM_SLOW_NS[3]),
      ns2cyc(WARM_SLOW_NS[4]), ns2cyc(WARM_SLOW_NS[5])}
)(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [DATA_W-1:0] rd_data,
   input  wire logic              wake_pin,
   input  wire logic [SRC_W-1:0]  irq_latch,
   input  wire logic              tbt_src_clk,
   input  wire logic              wdt_irq,
   output logic                   cpu_run,
   output logic                   wdt_run,
   output logic                   periph_clk_en,
   output logic                   tbt_clk_en,
   output logic                   hf_osc_en,
   output logic                   lf_osc_en,
   output logic                   tg_clear,
   output logic                   retain,
   output logic                   resume,
   output logic                   irq_service,
   output logic                   tbt_latch_set
);

   // ==========================================================
   // helpers
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      return a == off;
   endfunction

   // codes 000,010,100,110 map to 0..3, *01 to 4, *11 to 5
   function automatic logic [2:0] warm_idx(input logic [2:0] s);
      logic [2:0] i;
      i = {1'b0, s[2:1]};
      if (s[0]) begin
         i = s[1] ? 3'h5 : 3'h4;
      end
      return i;
   endfunction

   // ==========================================================
   // declarations
   smc_state_e        state_r;
   smc_state_e        state_nxt;
   logic              release_level_select_r;
   logic [2:0]        wut_r;
   logic              dual_r;
   logic              slow_r;
   logic              cpu_halt_r;
   logic              pclk_halt_r;
   logic              mie_r;
   logic              tbie_r;
   logic              tben_r;
   logic [SRC_W-1:0]  src_en_r;
   logic [31:0]       warm_cnt_r;
   logic [31:0]       warm_cnt_nxt;
   logic              wake_s1_r;
   logic              wake_s2_r;
   logic              wake_d_r;
   logic              tb_d_r;
   logic [DATA_W-1:0] rd_data_r;
   logic              cpu_run_r;
   logic              wdt_run_r;
   logic              periph_clk_en_r;
   logic              tbt_clk_en_r;
   logic              hf_osc_en_r;
   logic              lf_osc_en_r;
   logic              tg_clear_r;
   logic              retain_r;
   logic              resume_r;
   logic              irq_service_r;
   logic              tbt_latch_set_r;

   // ==========================================================
   // bus decode
   wire wr_mode   = wr_en & hit(addr, ADDR_MODE);
   wire wr_doze   = wr_en & hit(addr, ADDR_DOZE);
   wire wr_irqcfg = wr_en & hit(addr, ADDR_IRQCFG);
   wire wr_srcen  = wr_en & hit(addr, ADDR_SRCEN);

   wire st_run   = (state_r == ST_RUN);
   wire st_halt  = (state_r == ST_HALT);
   wire st_warm  = (state_r == ST_WARM);
   wire st_cdoze = (state_r == ST_CDOZE);
   wire st_gdoze = (state_r == ST_GDOZE);

   // ==========================================================
   // commands, only honoured while the cpu runs
   wire halt_cmd  = wr_mode & wr_data[BIT_HALT_CMD] & st_run;
   wire cdoze_cmd = wr_doze & wr_data[BIT_CPU_HALT] & st_run;
   // both bits at once is illegal; cpu doze wins
   wire gdoze_cmd = wr_doze & wr_data[BIT_PCLK_HLT]
                    & ~wr_data[BIT_CPU_HALT] & st_run;
   wire wdt_block = wdt_irq & (cdoze_cmd | gdoze_cmd);
   wire cdoze_go  = cdoze_cmd & ~wdt_block;
   wire gdoze_go  = gdoze_cmd & ~wdt_block;

   // ==========================================================
   // wake pin
   // edge seen only after synchroniser
   wire wake_rise = wake_s2_r & ~wake_d_r;
   // level mode with pin already high skips the halt
   wire halt_skip = halt_cmd & wr_data[BIT_RELEASE_LEVEL_SELECT] & wake_s2_r;
   // edge mode halts regardless of pin
   wire halt_go   = halt_cmd & ~halt_skip;
   // edge mode needs a rising edge
   // key wake inputs have no path here
   wire wake_ok   = st_halt & (release_level_select_r ? wake_s2_r : wake_rise);

   // ==========================================================
   // doze release
   wire src_hit  = |(irq_latch & src_en_r);
   wire tb_fall  = tb_d_r & ~tbt_src_clk;
   wire tb_and3  = mie_r & tbie_r & tben_r;
   // any enabled source ends cpu doze
   wire cdoze_rel = st_cdoze & src_hit;
   // first fall may come early in the period
   wire gdoze_rel = st_gdoze & tb_fall;

   // ==========================================================
   // warm-up length
   // same-cycle mode write counts, else a level-mode skip warms with stale settings
   wire [2:0]  wut_sel  = wr_mode ? wr_data[BIT_WUT_HI:BIT_WUT_LO] : wut_r;
   wire        dual_sel = wr_mode ? wr_data[BIT_DUAL] : dual_r;
   wire        slow_sel = wr_mode ? wr_data[BIT_SLOW] : slow_r;
   // slow return only in dual-clock operation
   wire        ret_slow = dual_sel & slow_sel;
   wire [2:0]  widx     = warm_idx(wut_sel);
   // six settings from the select field
   wire [31:0] warm_tgt = ret_slow ? WARM_SLOW_CYC[widx]
                                   : WARM_FAST_CYC[widx];
   wire        warm_done = st_warm & (warm_cnt_r == 32'h0);
   wire        warm_load = halt_skip | wake_ok;

   // ==========================================================
   // state machine
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            if (halt_go) begin
               state_nxt = ST_HALT;
            end else if (halt_skip) begin
               state_nxt = ST_WARM;
            end else if (cdoze_go) begin
               state_nxt = ST_CDOZE;
            end else if (gdoze_go) begin
               state_nxt = ST_GDOZE;
            end
         end
         ST_HALT: begin
            if (wake_ok) begin
               state_nxt = ST_WARM;
            end
         end
         ST_WARM: begin
            if (warm_done) begin
               state_nxt = ST_RUN;
            end
         end
         ST_CDOZE: begin
            if (cdoze_rel) begin
               state_nxt = ST_RUN;
            end
         end
         ST_GDOZE: begin
            if (gdoze_rel) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   assign warm_cnt_nxt = warm_load ? 32'(warm_tgt - 32'h1)
                       : (st_warm & ~warm_done) ? 32'(warm_cnt_r - 32'h1)
                       : warm_cnt_r;

   // reset pin ends any halt at the next sys_clk rising edge
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r    <= ST_RUN;
         warm_cnt_r <= 32'h0;
      end else begin
         state_r    <= state_nxt;
         warm_cnt_r <= warm_cnt_nxt;
      end
   end

   // ==========================================================
   // input sampling
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wake_s1_r <= 1'b0;
         wake_s2_r <= 1'b0;
         wake_d_r  <= 1'b0;
         tb_d_r    <= 1'b0;
      end else begin
         wake_s1_r <= wake_pin;
         wake_s2_r <= wake_s1_r;
         wake_d_r  <= wake_s2_r;
         tb_d_r    <= tbt_src_clk;
      end
   end

   // ==========================================================
   // configuration registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         release_level_select_r <= 1'b0;
         wut_r  <= WUT_RST;
         dual_r <= 1'b0;
         slow_r <= 1'b0;
      end else if (wr_mode) begin
         release_level_select_r <= wr_data[BIT_RELEASE_LEVEL_SELECT];
         wut_r  <= wr_data[BIT_WUT_HI:BIT_WUT_LO];
         dual_r <= wr_data[BIT_DUAL];
         slow_r <= wr_data[BIT_SLOW];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mie_r  <= 1'b0;
         tbie_r <= 1'b0;
         tben_r <= 1'b0;
      end else if (wr_irqcfg) begin
         mie_r  <= wr_data[BIT_MIE];
         tbie_r <= wr_data[BIT_TBIE];
         tben_r <= wr_data[BIT_TBEN];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         src_en_r <= SRCEN_RST;
      end else if (wr_srcen) begin
         src_en_r <= wr_data[SRC_W-1:0];
      end
   end

   // ==========================================================
   // request fields: set on entry, cleared by release
   // auto-clear on release
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cpu_halt_r  <= 1'b0;
         pclk_halt_r <= 1'b0;
      end else begin
         cpu_halt_r  <= cdoze_go | (cpu_halt_r & ~cdoze_rel);
         pclk_halt_r <= gdoze_go | (pclk_halt_r & ~gdoze_rel);
      end
   end

   // ==========================================================
   // output flops, driven from the next state
   wire nx_run   = (state_nxt == ST_RUN);
   wire nx_halt  = (state_nxt == ST_HALT);
   wire nx_warm  = (state_nxt == ST_WARM);
   wire nx_cdoze = (state_nxt == ST_CDOZE);
   wire nx_gdoze = (state_nxt == ST_GDOZE);
   // oscillators stay on through doze; only deep halt stops them
   wire osc_on   = ~nx_halt;
   wire retain_nxt = ~nx_run;
   // master on gets the wake serviced
   // and-term one services the time base
   wire svc_nxt = wdt_block | (cdoze_rel & mie_r) | (gdoze_rel & tb_and3);
   // latch set at entry only when the time-base enable is on
   wire tbls_nxt = gdoze_go & tben_r;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cpu_run_r       <= 1'b1;
         wdt_run_r       <= 1'b1;
         periph_clk_en_r <= 1'b1;
         tbt_clk_en_r    <= 1'b1;
      end else begin
         // cpu doze stops cpu and watchdog
         cpu_run_r       <= nx_run;
         wdt_run_r       <= nx_run;
         // gated doze keeps only the time base
         periph_clk_en_r <= nx_run | nx_cdoze;
         tbt_clk_en_r    <= nx_run | nx_cdoze | nx_gdoze;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hf_osc_en_r <= 1'b1;
         lf_osc_en_r <= 1'b0;
      end else begin
         hf_osc_en_r <= osc_on & ~ret_slow;
         lf_osc_en_r <= osc_on & dual_sel;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tg_clear_r <= 1'b0;
         retain_r   <= 1'b0;
      end else begin
         tg_clear_r <= nx_halt | nx_warm;
         retain_r   <= retain_nxt;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         resume_r        <= 1'b0;
         irq_service_r   <= 1'b0;
         tbt_latch_set_r <= 1'b0;
      end else begin
         resume_r        <= nx_run & ~st_run;
         irq_service_r   <= svc_nxt;
         tbt_latch_set_r <= tbls_nxt;
      end
   end

   // ==========================================================
   // read path; unmapped and reserved bits read zero
   wire [DATA_W-1:0] rd_mode = {1'b0, 1'b0, slow_r, dual_r, wut_r, release_level_select_r};
   wire [DATA_W-1:0] rd_doze = {6'h00, pclk_halt_r, cpu_halt_r};
   wire [DATA_W-1:0] rd_icfg = {5'h00, tben_r, tbie_r, mie_r};
   wire [DATA_W-1:0] rd_stat = {1'b0, lf_osc_en_r, hf_osc_en_r, state_r};
   wire [DATA_W-1:0] rd_mux  =
        hit(addr, ADDR_MODE)   ? rd_mode :
        hit(addr, ADDR_DOZE)   ? rd_doze :
        hit(addr, ADDR_IRQCFG) ? rd_icfg :
        hit(addr, ADDR_SRCEN)  ? src_en_r :
        hit(addr, ADDR_STATUS) ? rd_stat : RD_ZERO;

   // data stand one cycle only, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rd_data_r <= RD_ZERO;
      end else begin
         rd_data_r <= rd_en ? rd_mux : RD_ZERO;
      end
   end

   // ==========================================================
   // ports
   assign rd_data       = rd_data_r;
   assign cpu_run       = cpu_run_r;
   assign wdt_run       = wdt_run_r;
   assign periph_clk_en = periph_clk_en_r;
   assign tbt_clk_en    = tbt_clk_en_r;
   assign hf_osc_en     = hf_osc_en_r;
   assign lf_osc_en     = lf_osc_en_r;
   assign tg_clear      = tg_clear_r;
   assign retain        = retain_r;
   assign resume        = resume_r;
   assign irq_service   = irq_service_r;
   assign tbt_latch_set = tbt_latch_set_r;

endmodule // smc_top

// ---- verification/smc_checker_assertions.sv ----
// port checker of the standby mode controller
`timescale 1ns/1ps
module smc_checker
   import smc_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic              wr_en,
   input wire logic              wake_pin,
   input wire logic              tbt_src_clk,
   input wire logic              wdt_irq,
   input wire logic              cpu_run,
   input wire logic              wdt_run,
   input wire logic              periph_clk_en,
   input wire logic              tbt_clk_en,
   input wire logic              hf_osc_en,
   input wire logic              lf_osc_en,
   input wire logic              tg_clear,
   input wire logic              resume,
   input wire logic              irq_service
);
   // ==========
   // derived views
   wire halted  = tg_clear && !hf_osc_en && !lf_osc_en;
   wire gated   = !periph_clk_en && tbt_clk_en;
   wire doze_wr = wr_en && (addr == ADDR_DOZE) && cpu_run;
   wire halt_wr = wr_en && (addr == ADDR_MODE) && wr_data[BIT_HALT_CMD] && !wr_data[BIT_RELEASE_LEVEL_SELECT];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // ==========
   // assertions
   a_halt_entry: assert property (halt_wr && cpu_run |=> halted && !cpu_run)
      else $error("halt command did not stop the clocks");
   a_halt_quiet: assert property ((!wake_pin)[*3] ##0 halted |=> halted)
      else $error("halt left without a wake rise");
   a_wake_release: assert property (halted && !wake_pin ##1 wake_pin[*2]
      |-> ##[1:3] (hf_osc_en || lf_osc_en)) else $error("wake rise did not start warm-up");
   a_warm_exit: assert property ($fell(tg_clear) |-> resume && cpu_run)
      else $error("warm-up end without resume");
   a_resume_once: assert property (resume |=> !resume && (cpu_run || $past(wr_en)))
      else $error("resume longer than one cycle");
   a_cdoze_entry: assert property (doze_wr && wr_data[0] && !wdt_irq
      |=> !cpu_run && !wdt_run && periph_clk_en) else $error("cpu doze entry wrong");
   a_wdt_block: assert property (doze_wr && (|wr_data[1:0]) && wdt_irq
      |=> cpu_run && irq_service) else $error("doze entered despite watchdog");
   a_gdoze_entry: assert property (doze_wr && wr_data[1:0] == 2'b10 && !wdt_irq
      |=> gated && !cpu_run) else $error("gated doze entry wrong");
   a_gdoze_release: assert property (gated && $past(gated) && $past(tbt_src_clk)
      && !tbt_src_clk |-> ##[1:2] resume) else $error("source fall did not end doze");

   c_warm: cover property (halted ##1 (hf_osc_en || lf_osc_en));
   c_cdoze: cover property (periph_clk_en && !cpu_run ##1 resume);
   c_gdoze: cover property (gated ##1 resume && irq_service);
endmodule // smc_checker

bind smc_top smc_checker i_smc_checker (.*);

// ---- verification/smc_partner.sv ----
// far side model: wake pin, interrupt sources, time-base clock
`timescale 1ns/1ps
module smc_partner (
   input  wire logic       sys_clk,
   input  wire logic       wake_req,
   input  wire logic       slow_ans,
   input  wire logic [7:0] irq_req,
   input  wire logic       wdt_req,
   input  wire logic       tbt_go,
   output logic            wake_pin = 1'b0,
   output logic [7:0]      irq_latch = 8'h00,
   output logic            tbt_src_clk = 1'b0,
   output logic            wdt_irq = 1'b0
);
   logic [2:0] lag_r = 3'h0;
   logic [1:0] div_r = 2'h0;

   // only the wake pin, no key wake inputs
   always @(posedge sys_clk) begin
      lag_r <= {lag_r[1:0], wake_req};
      wake_pin <= slow_ans ? lag_r[2] : wake_req;
   end

   // sources raise latches only when asked
   always @(posedge sys_clk) begin
      irq_latch <= irq_req;
      wdt_irq <= wdt_req;
   end

   // stands low while stopped, so no stray fall
   always @(posedge sys_clk) begin
      div_r <= (!tbt_go || div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
      if (!tbt_go)
         tbt_src_clk <= 1'b0;
      else if (div_r == 2'h2)
         tbt_src_clk <= ~tbt_src_clk;
   end
endmodule // smc_partner

// ---- verification/smc_top_tb.sv ----
// self-checking bench of the standby mode controller
`timescale 1ns/1ps
module smc_top_tb
   import smc_pkg::*;
;
   localparam int unsigned FAST [0:5] = '{12, 10, 8, 6, 4, 2};
   localparam int unsigned SLOW [0:5] = '{30, 26, 22, 18, 14, 11};
   localparam int          IDX  [0:7] = '{0, 4, 1, 5, 2, 4, 3, 5};

   typedef struct {logic we; logic [2:0] a; logic [7:0] d; logic [7:0] e;} smc_row_s;
   smc_row_s rows [0:8] = '{
      '{1'b0, 3'h0, 8'h00, 8'h00}, '{1'b0, 3'h1, 8'h00, 8'h00},
      '{1'b0, 3'h2, 8'h00, 8'h00}, '{1'b0, 3'h3, 8'h00, 8'h00},
      '{1'b1, 3'h4, 8'h00, 8'h21}, '{1'b1, 3'h2, 8'h07, 8'h07},
      '{1'b1, 3'h3, 8'ha5, 8'ha5}, '{1'b1, 3'h0, 8'h3e, 8'h3e},
      '{1'b1, 3'h5, 8'hff, 8'h00}};

   logic              sys_clk, wake_pin, tbt_src_clk, wdt_irq;
   logic              rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic [ADDR_W-1:0] addr = 3'h0;
   logic [DATA_W-1:0] wr_data = 8'h00, rd_data;
   logic [SRC_W-1:0]  irq_latch, irq_req = 8'h00;
   logic              cpu_run, wdt_run, periph_clk_en, tbt_clk_en, hf_osc_en, lf_osc_en;
   logic              tg_clear, retain, resume, irq_service, tbt_latch_set;
   logic              wake_req = 1'b0, slow_ans = 1'b0, wdt_req = 1'b0, tbt_go = 1'b0;
   int                error_cnt = 0, samples_checked = 0;

   smc_top #(.WARM_FAST_CYC(FAST), .WARM_SLOW_CYC(SLOW)) i_smc_top (
      .sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .wake_pin(wake_pin),
      .irq_latch(irq_latch), .tbt_src_clk(tbt_src_clk), .wdt_irq(wdt_irq),
      .cpu_run(cpu_run), .wdt_run(wdt_run), .periph_clk_en(periph_clk_en),
      .tbt_clk_en(tbt_clk_en), .hf_osc_en(hf_osc_en), .lf_osc_en(lf_osc_en),
      .tg_clear(tg_clear), .retain(retain), .resume(resume),
      .irq_service(irq_service), .tbt_latch_set(tbt_latch_set));

   smc_partner i_smc_partner (
      .sys_clk(sys_clk), .wake_req(wake_req), .slow_ans(slow_ans), .irq_req(irq_req),
      .wdt_req(wdt_req), .tbt_go(tbt_go), .wake_pin(wake_pin), .irq_latch(irq_latch),
      .tbt_src_clk(tbt_src_clk), .wdt_irq(wdt_irq));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ==========
   // helpers
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask

   // bounded wait for run; counts warm-up cycles and keeps oscillator state
   task automatic to_run(output int warm, output logic [1:0] o);
      warm = 0;
      o = 2'h0;
      for (int i = 0; i < 300 && cpu_run !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
         if ((hf_osc_en | lf_osc_en) === 1'b1 && cpu_run === 1'b0) begin
            warm++;
            o = {hf_osc_en, lf_osc_en};
         end
      end
      if (cpu_run !== 1'b1) begin
         chk("run wait", 0, 1);
         report_and_stop();
      end
   endtask

   // ==========
   // main sequence
   initial begin
      logic [7:0] v;
      logic [1:0] o;
      int n;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].we)
            wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v);
         chk("register", v, rows[i].e);
      end
      // every warm-up code, single clock, then dual fast and dual slow
      for (int i = 0; i < 10; i++) begin
         logic d, s;
         logic [2:0] c;
         d = (i >= 8);
         s = (i == 9);
         c = (i < 8) ? i[2:0] : ((i == 8) ? 3'h3 : 3'h1);
         slow_ans <= i[0];
         if (i == 0)
            wake_req <= 1'b1;
         tick(4);
         wr(ADDR_MODE, {2'b10, s, d, c, 1'b0});
         tick(4);
         chk("halt", {cpu_run, hf_osc_en, lf_osc_en, tg_clear}, 4'b0001);
         wake_req <= 1'b0;
         tick(8);
         chk("halt hold", {cpu_run, tg_clear}, 2'b01);
         wake_req <= 1'b1;
         to_run(n, o);
         chk("warm osc", o, {~(d & s), d});
         chk("warm len", n, (d & s) ? SLOW[IDX[c]] : FAST[IDX[c]]);
         chk("resume", {resume, tg_clear}, 2'b10);
         tick(1);
         chk("resume pulse", resume, 1'b0);
         wake_req <= 1'b0;
      end
      // reset pin low ends halt
      wr(ADDR_MODE, 8'h80);
      tick(3);
      chk("reset entry", tg_clear, 1'b1);
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      tick(1);
      chk("reset exit", {cpu_run, hf_osc_en, lf_osc_en, tg_clear}, 4'b1100);
      rd(ADDR_MODE, v);
      chk("reset mode", v, 8'h00);
      // level release with the pin already high skips the halt
      wake_req <= 1'b1;
      tick(6);
      wr(ADDR_MODE, 8'h87);
      #1;
      chk("level skip", {cpu_run, hf_osc_en, tg_clear}, 3'b011);
      to_run(n, o);
      chk("level warm", n + 1, FAST[IDX[3]]);
      wake_req <= 1'b0;
      // cpu doze, masked then serviced release
      wr(ADDR_SRCEN, 8'h04);
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_IRQCFG, {7'h0, m[0]});
         wr(ADDR_DOZE, 8'h01);
         #1;
         chk("cpu doze", {cpu_run, wdt_run, periph_clk_en, retain}, 4'b0011);
         irq_req <= 8'h02;
         tick(5);
         chk("masked source", cpu_run, 1'b0);
         irq_req <= 8'h06;
         to_run(n, o);
         chk("doze wake", {resume, irq_service}, {1'b1, m[0]});
         irq_req <= 8'h00;
         rd(ADDR_DOZE, v);
         chk("doze clear", v, 8'h00);
      end
      // pending watchdog blocks both doze kinds
      wdt_req <= 1'b1;
      tick(2);
      for (int k = 1; k < 3; k++) begin
         wr(ADDR_DOZE, k[7:0]);
         #1;
         chk("watchdog", {cpu_run, irq_service}, 2'b11);
         tick(1);
      end
      wdt_req <= 1'b0;
      // gated doze over the three enable mixes
      for (int j = 0; j < 3; j++) begin
         logic [2:0] g;
         g = (j == 0) ? 3'h0 : ((j == 1) ? 3'h4 : 3'h7);
         wr(ADDR_IRQCFG, {5'h0, g});
         // time-base source held still before entry
         tbt_go <= 1'b0;
         wr(ADDR_DOZE, 8'h02);
         #1;
         chk("gated", {cpu_run, periph_clk_en, tbt_clk_en, tbt_latch_set}, {3'b001, g[2]});
         tick(4);
         chk("gated hold", cpu_run, 1'b0);
         tbt_go <= 1'b1;
         to_run(n, o);
         chk("gated wake", {resume, irq_service}, {1'b1, &g});
         tbt_go <= 1'b0;
         rd(ADDR_DOZE, v);
         chk("gated clear", v, 8'h00);
      end
      report_and_stop();
   end
endmodule // smc_top_tb
